// ==== rtl/spp_pin_mux.sv ====
// Output source selection and driver enables for each pin
`timescale 1ns/10ps
`default_nettype none
module spp_pin_mux (
   spp_steer_if.mux bus
);
   logic on_cb0, on_cb4, on_ca2, on_ca5, on_lc2, on_lc4, on_osc1, on_osc5;

   // Function follows its selected pin only; the other pin falls to the next source or the latch
   assign on_cb0  = bus.pen[spp_pkg::SPP_PEN_CB]  & ~bus.steer[spp_pkg::SPP_SEL_CB];
   assign on_cb4  = bus.pen[spp_pkg::SPP_PEN_CB]  &  bus.steer[spp_pkg::SPP_SEL_CB];
   assign on_ca2  = bus.pen[spp_pkg::SPP_PEN_CA]  & ~bus.steer[spp_pkg::SPP_SEL_CA];
   assign on_ca5  = bus.pen[spp_pkg::SPP_PEN_CA]  &  bus.steer[spp_pkg::SPP_SEL_CA];
   assign on_lc2  = bus.pen[spp_pkg::SPP_PEN_LC]  & ~bus.steer[spp_pkg::SPP_SEL_LC];
   assign on_lc4  = bus.pen[spp_pkg::SPP_PEN_LC]  &  bus.steer[spp_pkg::SPP_SEL_LC];
   assign on_osc1 = bus.pen[spp_pkg::SPP_PEN_OSC] & ~bus.steer[spp_pkg::SPP_SEL_OSC];
   assign on_osc5 = bus.pen[spp_pkg::SPP_PEN_OSC] &  bus.steer[spp_pkg::SPP_SEL_OSC];

   // Highest priority source first, latch last
   assign bus.pin_out[0] = on_cb0 ? bus.cb_val : bus.lat[0]; // [RULE6] [RULE19] [RULE4]
   assign bus.pin_out[1] = on_osc1 ? bus.osc_val : bus.lat[1]; // [RULE10]
   assign bus.pin_out[2] = on_ca2 ? bus.ca_val :
                           on_lc2 ? bus.lc_val : bus.lat[2]; // [RULE7] [RULE9] [RULE19]
   assign bus.pin_out[3] = 1'b0;
   assign bus.pin_out[4] = on_cb4 ? bus.cb_val :
                           on_lc4 ? bus.lc_val : bus.lat[4]; // [RULE6] [RULE9] [RULE19]
   assign bus.pin_out[5] = on_ca5 ? bus.ca_val :
                           on_osc5 ? bus.osc_val : bus.lat[5]; // [RULE7] [RULE10] [RULE19]

   // Driver follows the direction bit whatever the analog select says
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_oe
         if (gi == spp_pkg::SPP_IN_ONLY) begin : g_in
            assign bus.pin_oe[gi] = 1'b0; // [RULE13]
         end else begin : g_io
            assign bus.pin_oe[gi] = ~bus.dir[gi]; // [RULE12] [RULE15] [RULE17]
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== rtl/spp_pkg.sv ====
// Constants, register map and decode helper for the six-pin port
package spp_pkg;

   localparam int unsigned SPP_PINS = 6;

   // Register byte offsets on the APB bus
   localparam logic [7:0] SPP_OFF_PORT  = 8'h00;
   localparam logic [7:0] SPP_OFF_DIR   = 8'h04;
   localparam logic [7:0] SPP_OFF_LAT   = 8'h08;
   localparam logic [7:0] SPP_OFF_ANSEL = 8'h0C;
   localparam logic [7:0] SPP_OFF_STEER = 8'h10;
   localparam logic [7:0] SPP_OFF_PEN   = 8'h14;

   // Values after reset
   localparam logic [5:0] SPP_DIR_RST   = 6'h3F;
   localparam logic [5:0] SPP_LAT_RST   = 6'h00;
   localparam logic [5:0] SPP_ANSEL_RST = 6'h17;
   localparam logic [7:0] SPP_STEER_RST = 8'h00;
   localparam logic [3:0] SPP_PEN_RST   = 4'h0;

   // Implemented bits per register, and direction bits that read one
   localparam logic [5:0] SPP_PIN_MASK   = 6'h37;
   localparam logic [5:0] SPP_ANSEL_MASK = 6'h17;
   localparam logic [7:0] SPP_STEER_MASK = 8'hCB;
   localparam logic [5:0] SPP_DIR_ONES   = 6'h08;

   // Steering bit positions
   localparam int unsigned SPP_SEL_CB  = 7;
   localparam int unsigned SPP_SEL_CA  = 6;
   localparam int unsigned SPP_SEL_TG  = 3;
   localparam int unsigned SPP_SEL_LC  = 1;
   localparam int unsigned SPP_SEL_OSC = 0;

   // Peripheral output enable bit positions
   localparam int unsigned SPP_PEN_OSC = 0;
   localparam int unsigned SPP_PEN_LC  = 1;
   localparam int unsigned SPP_PEN_CA  = 2;
   localparam int unsigned SPP_PEN_CB  = 3;

   // Input-only pin
   localparam int unsigned SPP_IN_ONLY = 3;

   typedef enum logic [2:0] {
      SPP_R_PORT, SPP_R_DIR, SPP_R_LAT, SPP_R_ANSEL, SPP_R_STEER, SPP_R_PEN,
      SPP_R_NONE
   } spp_reg_t;

   function automatic spp_reg_t spp_decode(input logic [7:0] addr);
      case (addr)
         SPP_OFF_PORT:  spp_decode = SPP_R_PORT;
         SPP_OFF_DIR:   spp_decode = SPP_R_DIR;
         SPP_OFF_LAT:   spp_decode = SPP_R_LAT;
         SPP_OFF_ANSEL: spp_decode = SPP_R_ANSEL;
         SPP_OFF_STEER: spp_decode = SPP_R_STEER;
         SPP_OFF_PEN:   spp_decode = SPP_R_PEN;
         default:       spp_decode = SPP_R_NONE;
      endcase
   endfunction

endpackage

// ==== rtl/spp_port.sv ====
// Six-pin general purpose port with pin steering, APB register slave
//
// Overview of operation
// RULE1: latch register write equals port data write
// RULE2: latch read gives latch, port gives pins
// RULE3: analog select blocks digital input, reads zero
// RULE4: enabled peripheral overrides latch, pin stays readable
// RULE5: steering leaves direction; overrides follow function
// RULE6: bit 7 puts output B on pin4/pin0
// RULE7: bit 6 puts output A on pin5/pin2
// RULE8: bit 3 takes timer gate pin3/pin4
// RULE9: bit 1 puts logic cell pin4/pin2
// RULE10: bit 0 puts oscillator pin5/pin1
// RULE11: six pins, direction, latch, read bit each
// RULE12: direction one disables driver, zero drives latch
// RULE13: pin3 input only, direction reads one
// RULE14: port data write stores into output latch
// RULE15: direction still gates drivers on analog pins
// RULE16: analog pins always read zero digitally
// RULE17: analog select never affects digital outputs
// RULE18: analog select resets to analog mode
// RULE19: highest priority enabled source owns pin
// RULE20: pins synchronised twice, writes on clock edge
`timescale 1ns/10ps
`default_nettype none
module spp_port (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Port pins
   input  wire logic [5:0]  pin_in,
   output logic      [5:0]  pin_out,
   output logic      [5:0]  pin_oe,
   // Peripheral outputs to steer
   input  wire logic        oscillator_output,
   input  wire logic        first_logic_cell_output,
   input  wire logic        complementary_output_a,
   input  wire logic        complementary_output_b,
   // Peripheral input steered from the pins
   output logic             timer_gate_input
);

   spp_steer_if sif ();

   logic [5:0]       dir_q;
   logic [5:0]       dir_d;
   logic [5:0]       lat_q;
   logic [5:0]       lat_d;
   logic [5:0]       ansel_q;
   logic [5:0]       ansel_d;
   logic [7:0]       pin_steering_control_q;
   logic [7:0]       steer_d;
   logic [3:0]       pen_q;
   logic [3:0]       pen_d;
   logic [31:0]      prdata_d;
   logic [5:0]       pin_sync;
   logic [5:0]       pin_read;
   logic [5:0]       dir_rd;
   spp_pkg::spp_reg_t sel_reg;
   logic             setup_ph;
   logic             access_ph;
   logic             wr_ok;
   logic             wr_port;
   logic             wr_dir;
   logic             wr_lat;
   logic             wr_ansel;
   logic             wr_steer;
   logic             wr_pen;
   logic [5:0]       wdata6;

   // Bus phase decode
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign sel_reg   = spp_pkg::spp_decode(paddr);
   assign pready    = access_ph;
   assign pslverr   = access_ph & (sel_reg == spp_pkg::SPP_R_NONE);

   // Only the low byte lane holds register bits
   assign wr_ok    = access_ph & pwrite & pstrb[0];
   assign wr_port  = wr_ok & (sel_reg == spp_pkg::SPP_R_PORT);
   assign wr_dir   = wr_ok & (sel_reg == spp_pkg::SPP_R_DIR);
   assign wr_lat   = wr_ok & (sel_reg == spp_pkg::SPP_R_LAT);
   assign wr_ansel = wr_ok & (sel_reg == spp_pkg::SPP_R_ANSEL);
   assign wr_steer = wr_ok & (sel_reg == spp_pkg::SPP_R_STEER);
   assign wr_pen   = wr_ok & (sel_reg == spp_pkg::SPP_R_PEN);
   assign wdata6   = pwdata[5:0];

   // A whole byte write replaces every bit of the pin image read back,
   // so the stored result is the written value either way
   assign lat_d = (wr_port | wr_lat) ?
                  (wdata6 & spp_pkg::SPP_PIN_MASK) : lat_q; // [RULE1] [RULE14]
   // Steering writes never reach the direction bits
   assign dir_d = wr_dir ? (wdata6 & spp_pkg::SPP_PIN_MASK) : dir_q; // [RULE5]
   assign ansel_d = wr_ansel ?
                    (wdata6 & spp_pkg::SPP_ANSEL_MASK) : ansel_q;
   assign steer_d = wr_steer ?
                    (pwdata[7:0] & spp_pkg::SPP_STEER_MASK)
                    : pin_steering_control_q;
   assign pen_d = wr_pen ? pwdata[3:0] : pen_q;

   // Input-only pin has no direction flop; its bit always reads one
   assign dir_rd = dir_q | spp_pkg::SPP_DIR_ONES; // [RULE13]

   // Digital input buffer off on analog pins
   assign pin_read = pin_sync & ~ansel_q; // [RULE3] [RULE16]

   // Timer gate taken from the selected pin, as the pin reads digitally
   assign timer_gate_input =
      pin_steering_control_q[spp_pkg::SPP_SEL_TG] ? pin_read[3]
                                                  : pin_read[4]; // [RULE8]

   // Read data multiplexer
   assign prdata_d =
      (sel_reg == spp_pkg::SPP_R_PORT)  ? {26'h0000000, pin_read} : // [RULE2]
      (sel_reg == spp_pkg::SPP_R_DIR)   ? {26'h0000000, dir_rd} :
      (sel_reg == spp_pkg::SPP_R_LAT)   ? {26'h0000000, lat_q} : // [RULE2]
      (sel_reg == spp_pkg::SPP_R_ANSEL) ? {26'h0000000, ansel_q} :
      (sel_reg == spp_pkg::SPP_R_STEER) ?
         {24'h000000, pin_steering_control_q} :
      (sel_reg == spp_pkg::SPP_R_PEN)   ? {28'h0000000, pen_q} :
      32'h00000000;

   // Registers take writes on the clock edge of the access phase
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dir_q                  <= spp_pkg::SPP_DIR_RST & spp_pkg::SPP_PIN_MASK;
         lat_q                  <= spp_pkg::SPP_LAT_RST;
         ansel_q                <= spp_pkg::SPP_ANSEL_RST; // [RULE18]
         pin_steering_control_q <= spp_pkg::SPP_STEER_RST;
         pen_q                  <= spp_pkg::SPP_PEN_RST;
      end else begin
         dir_q                  <= dir_d; // [RULE20]
         lat_q                  <= lat_d;
         ansel_q                <= ansel_d;
         pin_steering_control_q <= steer_d;
         pen_q                  <= pen_d;
      end
   end

   // Read data sampled in setup, so it stands for the whole access phase
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (setup_ph & ~pwrite) begin
         prdata <= prdata_d;
      end
   end

   spp_sync u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (pin_in),
      .sync_out (pin_sync)
   ); // [RULE20] [RULE11]

   // Hand register state and peripheral levels to the pin mux
   assign sif.steer   = pin_steering_control_q;
   assign sif.pen     = pen_q;
   assign sif.lat     = lat_q;
   assign sif.dir     = dir_q;
   assign sif.osc_val = oscillator_output;
   assign sif.lc_val  = first_logic_cell_output;
   assign sif.ca_val  = complementary_output_a;
   assign sif.cb_val  = complementary_output_b;

   spp_pin_mux u_mux (
      .bus (sif.mux)
   );

   assign pin_out = sif.pin_out;
   assign pin_oe  = sif.pin_oe;

   // Checks
   default clocking cb_main @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   latch_alias_a: assert property ( // [RULE1]
      (wr_port | wr_lat) |=> lat_q == ($past(pwdata[5:0]) & 6'h37))
      else $error("latch not updated by port or latch write");

   port_read_a: assert property ( // [RULE2]
      (setup_ph & ~pwrite & (sel_reg == spp_pkg::SPP_R_PORT))
      |=> prdata[5:0] == $past(pin_sync & ~ansel_q))
      else $error("port read does not show pin levels");

   lat_read_a: assert property ( // [RULE2]
      (setup_ph & ~pwrite & (sel_reg == spp_pkg::SPP_R_LAT))
      |=> prdata[5:0] == $past(lat_q))
      else $error("latch read does not show latch");

   analog_zero_a: assert property ( // [RULE3]
      (pin_read & ansel_q) == 6'h00)
      else $error("analog pin reads nonzero");

   analog_read_a: assert property ( // [RULE16]
      (setup_ph & ~pwrite & (sel_reg == spp_pkg::SPP_R_PORT) & ansel_q[0])
      |=> prdata[0] == 1'b0)
      else $error("analog pin returned one on port read");

   periph_own_a: assert property ( // [RULE4]
      (pen_q[spp_pkg::SPP_PEN_OSC] & ~pin_steering_control_q[0])
      |-> pin_out[1] == oscillator_output)
      else $error("latch still drives pin with oscillator on");

   steer_dir_a: assert property ( // [RULE5]
      wr_steer |=> dir_q == $past(dir_q))
      else $error("steering write changed direction");

   unsel_pin_a: assert property ( // [RULE5]
      (pin_steering_control_q[spp_pkg::SPP_SEL_CB] & ~pen_q[1])
      |-> pin_out[0] == lat_q[0])
      else $error("unselected pin lost its latch");

   cb_route_a: assert property ( // [RULE6]
      pen_q[spp_pkg::SPP_PEN_CB] |->
      (pin_steering_control_q[7] ? pin_out[4] : pin_out[0])
      == complementary_output_b)
      else $error("output B on wrong pin");

   ca_route_a: assert property ( // [RULE7]
      pen_q[spp_pkg::SPP_PEN_CA] |->
      (pin_steering_control_q[6] ? pin_out[5] : pin_out[2])
      == complementary_output_a)
      else $error("output A on wrong pin");

   gate_route_a: assert property ( // [RULE8]
      timer_gate_input == (pin_steering_control_q[3] ? pin_read[3]
                                                      : pin_read[4]))
      else $error("timer gate from wrong pin");

   lc_route_a: assert property ( // [RULE9]
      (pen_q[spp_pkg::SPP_PEN_LC] & ~pen_q[3] & ~pen_q[2]) |->
      (pin_steering_control_q[1] ? pin_out[4] : pin_out[2])
      == first_logic_cell_output)
      else $error("logic cell on wrong pin");

   osc_route_a: assert property ( // [RULE10]
      (pen_q[spp_pkg::SPP_PEN_OSC] & ~pen_q[2]) |->
      (pin_steering_control_q[0] ? pin_out[5] : pin_out[1])
      == oscillator_output)
      else $error("oscillator on wrong pin");

   dir_drive_a: assert property ( // [RULE12]
      (~dir_q[2] & pen_q == 4'h0) |-> pin_oe[2] & (pin_out[2] == lat_q[2]))
      else $error("output pin does not drive latch");

   input_only_a: assert property ( // [RULE13]
      ~pin_oe[3] & dir_rd[3])
      else $error("input-only pin driven or direction clear");

   analog_oe_a: assert property ( // [RULE15]
      ansel_q[1] |-> pin_oe[1] == ~dir_q[1])
      else $error("analog pin ignores direction");

   analog_out_a: assert property ( // [RULE17]
      (ansel_q[0] & ~dir_q[0] & ~pen_q[3]) |-> pin_out[0] == lat_q[0])
      else $error("analog select blocked digital output");

   ansel_reset_a: assert property ( // [RULE18]
      $past(!rst_n) |-> ansel_q == 6'h17)
      else $error("analog select not set after reset");

   prio_a: assert property ( // [RULE19]
      (pen_q[2] & pen_q[1] & ~pin_steering_control_q[6]
       & ~pin_steering_control_q[1]) |-> pin_out[2] == complementary_output_a)
      else $error("lower priority source won pin");

   sync_delay_a: assert property ( // [RULE20]
      ($past(rst_n) & $past(rst_n, 2)) |-> pin_sync == $past(pin_in, 2))
      else $error("pin read not two cycles behind pin");

   port_write_c: cover property (wr_port);
   steer_move_c: cover property (wr_steer ##1 pen_q != 4'h0);
   analog_read_c: cover property (setup_ph & ~pwrite & ansel_q != 6'h00);
   unmapped_c: cover property (pslverr);

endmodule
`default_nettype wire

// ==== rtl/spp_steer_if.sv ====
// Carrier between the register block and the pin steering mux
`timescale 1ns/10ps
`default_nettype none
interface spp_steer_if;
   logic [7:0] steer;
   logic [3:0] pen;
   logic [5:0] lat;
   logic [5:0] dir;
   logic       osc_val;
   logic       lc_val;
   logic       ca_val;
   logic       cb_val;
   logic [5:0] pin_out;
   logic [5:0] pin_oe;

   modport ctrl (output steer, pen, lat, dir, osc_val, lc_val, ca_val,
                 cb_val, input pin_out, pin_oe);
   modport mux  (input steer, pen, lat, dir, osc_val, lc_val, ca_val,
                 cb_val, output pin_out, pin_oe);
endinterface
`default_nettype wire

// ==== rtl/spp_sync.sv ====
// Two-flop synchroniser for the pin levels
`timescale 1ns/10ps
`default_nettype none
module spp_sync (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Levels
   input  wire logic [5:0] async_in,
   output logic      [5:0] sync_out
);
   logic [5:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q   <= 6'h00;
         sync_out <= 6'h00;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== tb/spp_pin_model.sv ====
// External circuitry on the six port pins
`timescale 1ns/10ps
`default_nettype none
module spp_pin_model (
   // Port side
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   // Level forced by outside parts where the port does not drive
   input  wire logic [5:0] ext_lvl,
   // Resolved pin level
   output logic      [5:0] pin_in
);
   // Enabled driver wins; outside parts are weak
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the six-pin port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   typedef struct {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } spp_row_t;

   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [3:0]  pstrb   = 4'hF;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  pin_in;
   logic [5:0]  pin_out;
   logic [5:0]  pin_oe;
   logic [5:0]  ext_lvl = 6'h3F;
   logic [3:0]  per     = 4'h0;
   logic        tg;
   logic        err_q;
   logic [31:0] rd;
   int          failures    = 0;
   int          checks_done = 0;
   int          cycles      = 0;
   int          pos;
   int          sbit [4] = '{0, 1, 6, 7};
   int          dflt [4] = '{1, 2, 2, 0};
   int          alt  [4] = '{5, 4, 5, 4};

   // Reads after reset, then write and read back each register other than the port data register, then an unmapped write
   spp_row_t rows [17] = '{
      '{1'b0, 8'h04, 32'h00, 32'h3F, 1'b0}, '{1'b0, 8'h08, 32'h00, 32'h00, 1'b0},
      '{1'b0, 8'h0C, 32'h00, 32'h17, 1'b0}, '{1'b0, 8'h10, 32'h00, 32'h00, 1'b0},
      '{1'b0, 8'h14, 32'h00, 32'h00, 1'b0}, '{1'b0, 8'h00, 32'h00, 32'h28, 1'b0},
      '{1'b1, 8'h04, 32'h00, 32'h08, 1'b0}, '{1'b1, 8'h04, 32'hFF, 32'h3F, 1'b0},
      '{1'b1, 8'h08, 32'hFF, 32'h37, 1'b0}, '{1'b1, 8'h08, 32'h00, 32'h00, 1'b0},
      '{1'b1, 8'h0C, 32'hFF, 32'h17, 1'b0}, '{1'b1, 8'h0C, 32'h00, 32'h00, 1'b0},
      '{1'b1, 8'h10, 32'hFF, 32'hCB, 1'b0}, '{1'b1, 8'h10, 32'h00, 32'h00, 1'b0},
      '{1'b1, 8'h14, 32'hFF, 32'h0F, 1'b0}, '{1'b1, 8'h14, 32'h00, 32'h00, 1'b0},
      '{1'b1, 8'h18, 32'hFF, 32'h00, 1'b1}
   };

   spp_port i_dut (
      .sys_clk                 (sys_clk),
      .rst_n                   (rst_n),
      .psel                    (psel),
      .penable                 (penable),
      .pwrite                  (pwrite),
      .paddr                   (paddr),
      .pwdata                  (pwdata),
      .pstrb                   (pstrb),
      .prdata                  (prdata),
      .pready                  (pready),
      .pslverr                 (pslverr),
      .pin_in                  (pin_in),
      .pin_out                 (pin_out),
      .pin_oe                  (pin_oe),
      .oscillator_output       (per[0]),
      .first_logic_cell_output (per[1]),
      .complementary_output_a  (per[2]),
      .complementary_output_b  (per[3]),
      .timer_gate_input        (tg)
   );

   spp_pin_model i_pins (
      .pin_out (pin_out),
      .pin_oe  (pin_oe),
      .ext_lvl (ext_lvl),
      .pin_in  (pin_in)
   );

   always #10 sys_clk = ~sys_clk;

   task automatic wrap_up;
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Generous ceiling; the sequence needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask

   // One APB transfer; an idle cycle follows so calls never collide
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd      = prdata;
      err_q   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic run_rows(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         if (rows[i].wr) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk("wr_err", err_q, rows[i].e);
         end
         apb(1'b0, rows[i].a, 32'h0);
         chk("rd_data", rd, rows[i].x);
         chk("rd_err", err_q, rows[i].e);
      end
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      run_rows(0, 16);
      // Latch written through the port data register
      apb(1'b1, 8'h00, 32'h15);
      apb(1'b1, 8'h04, 32'h00);
      chk("oe", pin_oe, 6'h37);
      chk("out", pin_out, 6'h15);
      apb(1'b1, 8'h08, 32'h22);
      chk("out_lat", pin_out, 6'h22);
      repeat (2) @(posedge sys_clk);
      apb(1'b0, 8'h00, 32'h0);
      chk("pins", rd, 32'h2A);
      apb(1'b0, 8'h08, 32'h0);
      chk("lat", rd, 32'h22);
      // Analog select with drivers still on
      apb(1'b1, 8'h0C, 32'h17);
      chk("an_oe", pin_oe, 6'h37);
      chk("an_out", pin_out, 6'h22);
      repeat (2) @(posedge sys_clk);
      apb(1'b0, 8'h00, 32'h0);
      chk("an_pins", rd, 32'h28);
      apb(1'b1, 8'h04, 32'h3F);
      chk("an_dir", pin_oe, 6'h00);
      apb(1'b1, 8'h0C, 32'h00);
      apb(1'b1, 8'h04, 32'h00);
      // Each steered output on both of its pins
      for (int k = 0; k < 4; k++) begin
         for (int s = 0; s < 2; s++) begin
            pos = s ? alt[k] : dflt[k];
            per <= 4'hF;
            apb(1'b1, 8'h10, s ? (32'h1 << sbit[k]) : 32'h0);
            apb(1'b1, 8'h14, 32'h1 << k);
            apb(1'b1, 8'h08, 32'h00);
            chk("st_on", pin_out, 6'h01 << pos);
            per <= 4'h0;
            apb(1'b1, 8'h08, 32'h37);
            chk("st_off", pin_out, 6'h37 & ~(6'h01 << pos));
         end
      end
      apb(1'b0, 8'h04, 32'h0);
      chk("st_dir", rd, 32'h08);
      // Shared pins: higher priority source owns the pin
      apb(1'b1, 8'h10, 32'hCB);
      apb(1'b1, 8'h14, 32'h0F);
      apb(1'b1, 8'h08, 32'h00);
      for (int v = 3; v <= 12; v += 9) begin
         per <= v[3:0];
         repeat (2) @(posedge sys_clk);
         chk("prio", pin_out, {v[2], v[3], 4'h0});
      end
      // Timer gate taken from the selected pin
      apb(1'b1, 8'h14, 32'h00);
      apb(1'b1, 8'h04, 32'h3F);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, 8'h10, s ? 32'h08 : 32'h00);
         for (int e = 8; e <= 16; e += 8) begin
            ext_lvl <= e[5:0];
            repeat (3) @(posedge sys_clk);
            chk("gate", tg, s ? e[3] : e[4]);
         end
      end
      // Second reset in mid-run
      ext_lvl <= 6'h3F;
      rst_n   <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      chk("rst_oe", pin_oe, 6'h00);
      run_rows(0, 5);
      wrap_up();
   end
endmodule
`default_nettype wire
